// file: src/synth_loader_pkg.sv
// Constants for the serial register loader of the fractional-N synthesizer
// Notes on behaviour
// - Every programming word is 24 bits, fully shifted before any latch commit.
// - Bits arrive MSB first; last bit before the strobe is word bit 0.
// - Rising latch strobe copies the shift register into the addressed latch.
// - Low four bits address; bit0 zero means latch 0, else bits 3..1 pick 0..7.
// - Latch 0 holds 23 data bits: 11-bit integer over 12-bit numerator; others 20.
// - Writing latch 0 reinitialises lock detector and fast-lock circuitry.
// - That reinitialisation clears the lock counter and loads the fast-lock counter with all ones.
// - Modulator order field: 0 fourth, 2 second, 3 third order.
// - Dither field: 0 off, 1 weak, 2 strong.
// - Latch 2 (code 0101) holds 19-bit aux N value and aux power-down in bit 23.
package synth_loader_pkg;
  localparam int WORD_W = 24;
  localparam int ADDR_W = 4;
  localparam int NUM_LATCH = 8;
  localparam int LIDX_W = 3;
  // Latch 0 layout
  localparam int INT_DIV_LSB = 13;
  localparam int INT_DIV_W = 11;
  localparam int FRAC_NUM_LSB = 1;
  localparam int FRAC_NUM_W = 12;
  // Latch 1 layout
  localparam int MAIN_PD_BIT = 23;
  localparam int PRESC_BIT = 22;
  localparam int REF_DIV_LSB = 16;
  localparam int REF_DIV_W = 6;
  localparam int FRAC_DEN_LSB = 4;
  localparam int FRAC_DEN_W = 12;
  // Latch 2 layout
  localparam int AUX_PD_BIT = 23;
  localparam int AUX_N_LSB = 4;
  localparam int AUX_N_W = 19;
  // Latch 3 layout
  localparam int ACCESS_LSB = 20;
  localparam int ACCESS_W = 4;
  localparam int PUMP_GAIN_LSB = 16;
  localparam int PUMP_GAIN_W = 4;
  localparam int AUX_REF_LSB = 4;
  localparam int AUX_REF_W = 12;
  // Latch 4 layout: dither and modulator order
  localparam int DITHER_LSB = 16;
  localparam int MOD_ORDER_LSB = 14;
  localparam int FIELD2_W = 2;
  // Reset value and lock counter width
  localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;
  localparam logic [3:0] LOCK_CNT_W = 4'hc;
  typedef enum logic [1:0] {
    MOD_FOURTH = 2'b00,
    MOD_RSVD = 2'b01,
    MOD_SECOND = 2'b10,
    MOD_THIRD = 2'b11
  } mod_order_type;
  typedef enum logic [1:0] {
    DITHER_STRENGTH_OFF = 2'b00,
    DITHER_STRENGTH_WEAK = 2'b01,
    DITHER_STRENGTH_STRONG = 2'b10,
    DITHER_STRENGTH_RSVD = 2'b11
  } dither_type;
endpackage : synth_loader_pkg

// file: src/synth_serial_register_loader.sv
// Serial shift register, latch decode and divider-write reinitialisation
`timescale 1ns/100ps
`default_nettype none
module synth_serial_register_loader
  import synth_loader_pkg::*;
#(
  parameter int LOCK_CNT_BITS = 12
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Serial link pins
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  input wire logic latch_strobe_in,
  // Status from loop logic
  input wire logic lock_sample_in,
  // Main loop controls
  output logic [INT_DIV_W-1:0] main_integer_divider_out,
  output logic [FRAC_NUM_W-1:0] main_frac_numerator_out,
  output logic [FRAC_DEN_W-1:0] main_frac_denominator_out,
  output logic [REF_DIV_W-1:0] main_ref_divider_out,
  output logic main_power_down_out,
  output logic main_prescaler_sel_out,
  // Auxiliary loop controls
  output logic [AUX_N_W-1:0] aux_divider_out,
  output logic aux_power_down_out,
  output logic [AUX_REF_W-1:0] aux_ref_divider_out,
  output logic [PUMP_GAIN_W-1:0] pump_gain_sel_out,
  // Modulator controls
  output logic [FIELD2_W-1:0] modulator_order_sel_out,
  output logic [FIELD2_W-1:0] dither_strength_out,
  // Status and events
  output logic lock_detect_out,
  output logic fastlock_active_out,
  output logic [NUM_LATCH-1:0] latch_written_out
);

  // Three-stage synchronisers; edges judged on stages two and three
  logic [2:0] sclk_sync_r;
  logic [2:0] sdata_sync_r;
  logic [2:0] strobe_sync_r;
  logic sclk_level_r;
  logic strobe_level_r;
  logic sclk_rise;
  logic strobe_rise;

  // Word being shifted and the eight latches
  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] latch_r [NUM_LATCH];

  // Decode and write strobes
  logic [LIDX_W-1:0] latch_sel;
  logic [NUM_LATCH-1:0] latch_we;

  // Counters that a divider write restarts
  logic [LOCK_CNT_BITS-1:0] lock_cnt_r;
  logic [LOCK_CNT_BITS-1:0] fast_cnt_r;
  logic div_write;

  // Serial clock pin; a glitch shorter than one cycle never counts
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_sync_r <= 3'h0;
      sclk_level_r <= 1'b0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[1:0], serial_clk_in};
      if (sclk_sync_r[1] == sclk_sync_r[2]) begin
        sclk_level_r <= sclk_sync_r[2];
      end
    end
  end

  // Serial data pin; only looked at on a serial clock rise
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sdata_sync_r <= 3'h0;
    end else begin
      sdata_sync_r <= {sdata_sync_r[1:0], serial_data_in};
    end
  end

  // Latch strobe pin
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      strobe_sync_r <= 3'h0;
      strobe_level_r <= 1'b0;
    end else begin
      strobe_sync_r <= {strobe_sync_r[1:0], latch_strobe_in};
      if (strobe_sync_r[1] == strobe_sync_r[2]) begin
        strobe_level_r <= strobe_sync_r[2];
      end
    end
  end

  // Data taken from stage three, so host must hold data around the edge
  assign sclk_rise = sclk_sync_r[1] & sclk_sync_r[2] & ~sclk_level_r;
  assign strobe_rise = strobe_sync_r[1] & strobe_sync_r[2] & ~strobe_level_r;

  // Shift register keeps the most recent 24 bits, MSB first
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      shift_r <= LATCH_RESET;
    end else if (sclk_rise) begin
      shift_r <= {shift_r[WORD_W-2:0], sdata_sync_r[2]};
    end
  end

  // Address decode
  always_comb begin
    if (!shift_r[0]) begin
      latch_sel = 3'h0;
    end else begin
      latch_sel = shift_r[3:1];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_LATCH; g++) begin : g_latch
      assign latch_we[g] = strobe_rise && (latch_sel == LIDX_W'(g));
      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          latch_r[g] <= LATCH_RESET;
        end else if (latch_we[g]) begin
          latch_r[g] <= shift_r;
        end
      end
    end
  endgenerate

  assign div_write = latch_we[0];

  // Main loop fields, one cycle behind their latch
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      main_integer_divider_out <= '0;
      main_frac_numerator_out <= '0;
      main_frac_denominator_out <= '0;
      main_ref_divider_out <= '0;
      main_power_down_out <= 1'b0;
      main_prescaler_sel_out <= 1'b0;
    end else begin
      main_integer_divider_out <= latch_r[0][INT_DIV_LSB +: INT_DIV_W];
      main_frac_numerator_out <= latch_r[0][FRAC_NUM_LSB +: FRAC_NUM_W];
      main_frac_denominator_out <= latch_r[1][FRAC_DEN_LSB +: FRAC_DEN_W];
      main_ref_divider_out <= latch_r[1][REF_DIV_LSB +: REF_DIV_W];
      main_power_down_out <= latch_r[1][MAIN_PD_BIT];
      main_prescaler_sel_out <= latch_r[1][PRESC_BIT];
    end
  end

  // Auxiliary loop fields
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      aux_divider_out <= '0;
      aux_power_down_out <= 1'b0;
      aux_ref_divider_out <= '0;
      pump_gain_sel_out <= '0;
    end else begin
      aux_divider_out <= latch_r[2][AUX_N_LSB +: AUX_N_W];
      aux_power_down_out <= latch_r[2][AUX_PD_BIT];
      aux_ref_divider_out <= latch_r[3][AUX_REF_LSB +: AUX_REF_W];
      pump_gain_sel_out <= latch_r[3][PUMP_GAIN_LSB +: PUMP_GAIN_W];
    end
  end

  // Modulator fields; reserved codes pass through unchanged
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      modulator_order_sel_out <= '0;
      dither_strength_out <= '0;
    end else begin
      modulator_order_sel_out <= latch_r[4][MOD_ORDER_LSB +: FIELD2_W];
      dither_strength_out <= latch_r[4][DITHER_LSB +: FIELD2_W];
    end
  end

  // Write pulse leads the fields by one cycle
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      latch_written_out <= '0;
    end else begin
      latch_written_out <= latch_we;
    end
  end

  // Lock detector: counts consecutive good samples; a divider write or a bad sample clears it
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      lock_cnt_r <= '0;
      lock_detect_out <= 1'b0;
    end else if (div_write) begin
      lock_cnt_r <= '0;
      lock_detect_out <= 1'b0;
    end else if (!lock_sample_in) begin
      lock_cnt_r <= '0;
      lock_detect_out <= 1'b0;
    end else if (lock_cnt_r != '1) begin
      lock_cnt_r <= lock_cnt_r + 1'b1;
    end else begin
      lock_detect_out <= 1'b1;
    end
  end

  // Fast-lock window restarts on each divider write, then runs out
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      fast_cnt_r <= '0;
      fastlock_active_out <= 1'b0;
    end else if (div_write) begin
      fast_cnt_r <= '1;
      fastlock_active_out <= 1'b1;
    end else if (fast_cnt_r != '0) begin
      fast_cnt_r <= fast_cnt_r - 1'b1;
      fastlock_active_out <= (fast_cnt_r != LOCK_CNT_BITS'(1));
    end else begin
      fastlock_active_out <= 1'b0;
    end
  end

endmodule : synth_serial_register_loader
`default_nettype wire

// file: bench/loader_chk.sv
// Checker for the serial register loader outputs
`timescale 1ns/100ps
`default_nettype none
module loader_chk
  import synth_loader_pkg::*;
#(
  parameter int LOCK_CNT_BITS = 12
) (
  // Clock, reset and strobe pin
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic latch_strobe_in,
  // Watched outputs
  input wire logic [INT_DIV_W-1:0] main_integer_divider_out,
  input wire logic [FRAC_DEN_W-1:0] main_frac_denominator_out,
  input wire logic [AUX_N_W-1:0] aux_divider_out,
  input wire logic [FIELD2_W-1:0] dither_strength_out,
  input wire logic lock_detect_out,
  input wire logic fastlock_active_out,
  input wire logic [NUM_LATCH-1:0] latch_written_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  AST_ONE_LATCH: assert property ($onehot0(latch_written_out))
    else $error("more than one latch written at once");
  AST_STROBE_WRITE: assert property ($rose(latch_strobe_in) |-> ##4 |latch_written_out)
    else $error("strobe rise gave no latch write");
  AST_PULSE: assert property (|latch_written_out |=> !latch_written_out)
    else $error("write pulse longer than one cycle");
  AST_L0_HOLD: assert property (!$past(latch_written_out[0]) |->
    $stable(main_integer_divider_out))
    else $error("divider changed without its write");
  AST_L1_HOLD: assert property (!$past(latch_written_out[1]) |->
    $stable(main_frac_denominator_out))
    else $error("denominator changed without its write");
  AST_L2_HOLD: assert property (!$past(latch_written_out[2]) |->
    $stable(aux_divider_out))
    else $error("aux divider changed without its write");
  AST_L4_HOLD: assert property (!$past(latch_written_out[4]) |->
    $stable(dither_strength_out))
    else $error("dither changed without its write");
  AST_LOCK_CLR: assert property (latch_written_out[0] |-> ##[0:2] !lock_detect_out)
    else $error("lock detect not cleared by divider write");
  AST_FAST_ON: assert property (latch_written_out[0] |-> ##[0:2] fastlock_active_out)
    else $error("fast-lock not restarted by divider write");
endmodule : loader_chk
bind synth_serial_register_loader loader_chk #(
  .LOCK_CNT_BITS(LOCK_CNT_BITS)
) i_chk (
  .clock_in(clock_in),
  .rst_in(rst_in),
  .latch_strobe_in(latch_strobe_in),
  .main_integer_divider_out(main_integer_divider_out),
  .main_frac_denominator_out(main_frac_denominator_out),
  .aux_divider_out(aux_divider_out),
  .dither_strength_out(dither_strength_out),
  .lock_detect_out(lock_detect_out),
  .fastlock_active_out(fastlock_active_out),
  .latch_written_out(latch_written_out)
);
`default_nettype wire

// file: bench/serial_host_model.sv
// Host model driving the three-wire serial programming link
`timescale 1ns/100ps
`default_nettype none
module serial_host_model (
  // Serial link pins
  output logic sclk_out,
  output logic sdata_out,
  output logic strobe_out
);
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    strobe_out = 1'b0;
  end
  // Link clock idles low between frames; optional junk nibble goes first
  task automatic send(input logic [23:0] w, input bit junk);
    logic [27:0] s;
    int n;
    s = {4'ha, w};
    n = junk ? 28 : 24;
    for (int i = n - 1; i >= 0; i--) begin
      sdata_out <= s[i];
      #62.5 sclk_out <= 1'b1;
      #62.5 sclk_out <= 1'b0;
    end
    // Released data line shows the inverse, not a held bit
    sdata_out <= ~s[0];
    #50 strobe_out <= 1'b1;
    #60 strobe_out <= 1'b0;
    #40;
  endtask : send
endmodule : serial_host_model
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the serial register loader
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import synth_loader_pkg::*;
  logic clock_in = 1'b0, rst_in = 1'b1, lock_sample_in = 1'b0;
  logic serial_clk_in, serial_data_in, latch_strobe_in;
  logic [INT_DIV_W-1:0] main_integer_divider_out;
  logic [11:0] main_frac_numerator_out, main_frac_denominator_out, aux_ref_divider_out;
  logic [REF_DIV_W-1:0] main_ref_divider_out;
  logic main_power_down_out, main_prescaler_sel_out, aux_power_down_out;
  logic [AUX_N_W-1:0] aux_divider_out;
  logic [3:0] pump_gain_sel_out;
  logic [1:0] modulator_order_sel_out, dither_strength_out;
  logic lock_detect_out, fastlock_active_out;
  logic [7:0] latch_written_out, last_wr = 8'h00;
  int errors = 0, checks_done = 0;
  logic [1:0] ord [3] = '{2'h3, 2'h2, 2'h0};
  always #5 clock_in = ~clock_in;
  // Short lock counters keep the run brief
  synth_serial_register_loader #(.LOCK_CNT_BITS(6)) i_dut (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .serial_clk_in(serial_clk_in),
    .serial_data_in(serial_data_in),
    .latch_strobe_in(latch_strobe_in),
    .lock_sample_in(lock_sample_in),
    .main_integer_divider_out(main_integer_divider_out),
    .main_frac_numerator_out(main_frac_numerator_out),
    .main_frac_denominator_out(main_frac_denominator_out),
    .main_ref_divider_out(main_ref_divider_out),
    .main_power_down_out(main_power_down_out),
    .main_prescaler_sel_out(main_prescaler_sel_out),
    .aux_divider_out(aux_divider_out),
    .aux_power_down_out(aux_power_down_out),
    .aux_ref_divider_out(aux_ref_divider_out),
    .pump_gain_sel_out(pump_gain_sel_out),
    .modulator_order_sel_out(modulator_order_sel_out),
    .dither_strength_out(dither_strength_out),
    .lock_detect_out(lock_detect_out),
    .fastlock_active_out(fastlock_active_out),
    .latch_written_out(latch_written_out)
  );
  serial_host_model i_host (.sclk_out(serial_clk_in), .sdata_out(serial_data_in),
    .strobe_out(latch_strobe_in));
  always @(posedge clock_in) if (latch_written_out != 8'h00) last_wr <= latch_written_out;
  task chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [23:0] w, input bit junk, input logic [7:0] lw);
    i_host.send(w, junk);
    repeat (4) @(posedge clock_in);
    chk(last_wr, lw);
  endtask : wr
  task test_done;
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  initial begin
    #200us;
    errors++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    lock_sample_in <= 1'b1;
    repeat (80) @(posedge clock_in);
    chk(lock_detect_out, 1'b1);
    wr(24'haafff3, 0, 8'h02);
    chk({main_power_down_out, main_prescaler_sel_out, main_ref_divider_out}, 8'haa);
    wr(24'hda5a55, 0, 8'h04);
    chk({aux_power_down_out, aux_divider_out}, 20'hda5a5);
    wr(24'h19abc7, 0, 8'h08);
    chk({pump_gain_sel_out, aux_ref_divider_out}, 16'h9abc);
    wr(24'h00000f, 1, 8'h80);
    for (int m = 0; m < 3; m++) for (int d = 0; d < 3; d++) begin
      wr(24'h200009 | (24'(ord[m]) << 14) | (24'(d) << 16), 0, 8'h10);
      chk(modulator_order_sel_out, ord[m]);
      chk(dither_strength_out, d[1:0]);
    end
    // Divider word last, with stray bits above its single address bit
    wr(24'h2ab554, 0, 8'h01);
    chk({main_integer_divider_out, main_frac_numerator_out}, 23'h155aaa);
    chk({lock_detect_out, fastlock_active_out}, 2'b01);
    chk(main_frac_denominator_out, 12'hfff);
    repeat (80) @(posedge clock_in);
    chk({lock_detect_out, fastlock_active_out}, 2'b10);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
